/* include/modem_cfg_consts.vh */
// Constants for the modem control word and transmit time-out logic
`ifndef MODEM_CFG_CONSTS_VH
`define MODEM_CFG_CONSTS_VH
`define CW_WIDTH 24
`define CW_RESET 24'h1362d7
`define CW_FREQ_LSB 0
`define CW_FREQ_MSB 2
`define CW_BAUD_LSB 3
`define CW_BAUD_MSB 4
`define CW_DEV_BIT 5
`define CW_WDOG_BIT 6
`define CW_TX_TIMEOUT_FLAG_LSB 7
`define CW_TX_TIMEOUT_FLAG_MSB 8
`define CW_DET_LSB 9
`define CW_DET_MSB 10
`define CW_ZC_BIT 11
`define CW_METH_LSB 12
`define CW_METH_MSB 13
`define CW_ASYNC_BIT 14
`define CW_MCLK_LSB 15
`define CW_MCLK_MSB 16
`define CW_PKBR_LSB 17
`define CW_PKBR_MSB 18
`define CW_PKLEN_LSB 19
`define CW_PKLEN_MSB 20
`define CW_PKEN_BIT 21
`define CW_SENS_BIT 22
`define CW_PREF_BIT 23
`define TX_TIMEOUT_FLAG_OFF 2'h0
`define TX_TIMEOUT_FLAG_1S 2'h1
`define TX_TIMEOUT_FLAG_3S 2'h2
`define CLK_HZ 25000000
`define TX_TIMEOUT_FLAG_1S_MS 1000
`define TX_TIMEOUT_FLAG_3S_MS 3000
`define FLAG_HOLD_MS 125
`define WDOG_MS 1500
`define CYC_PER_MS (`CLK_HZ / 1000)
`endif

/* tb/host_model.sv */
// Host controller: drives mode selects and offers control words
`timescale 1ns/1ps
module host_model (
  input wire clock,
  input wire word_ready,
  output logic direction_select,
  output logic config_select,
  output logic word_valid,
  output logic [23:0] word_in
);
  initial begin
    direction_select = 1'b0;
    config_select = 1'b1;
    word_valid = 1'b0;
    word_in = 24'h0;
  end
  task automatic set_mode(input logic dir, input logic cfg);
    @(posedge clock);
    #2 direction_select = dir;
    config_select = cfg;
  endtask
  task automatic send(input logic [23:0] w);
    @(posedge clock);
    #2 word_valid = 1'b1;
    word_in = w;
    for (int i = 0; i < 200 && word_ready !== 1'b1; i++) begin
      @(posedge clock);
      #2;
    end
    @(posedge clock);
    #2 word_valid = 1'b0;
    word_in = ~w;
  endtask
endmodule // host_model

/* tb/modem_config_monitor.sv */
// Checker for the modem control word block
`timescale 1ns/1ps
module modem_config_monitor #(parameter HOLD_CYC = 20) (
  input wire clock,
  input wire rst_n,
  input wire direction_select,
  input wire config_select,
  input wire carrier_detect,
  input wire inband_signal,
  input wire [23:0] modem_control_word,
  input wire bit_clock_out,
  input wire rx_data_out,
  input wire band_busy_flag,
  input wire tx_timeout_flag,
  input wire tx_enable,
  input wire [2:0] carrier_sel,
  input wire [1:0] baud_sel,
  input wire deviation_full,
  input wire watchdog_enable,
  input wire [1:0] detect_time_sel,
  input wire zero_cross_sync,
  input wire async_mode,
  input wire [1:0] mclk_sel,
  input wire [1:0] packet_rate_sel,
  input wire [1:0] packet_len_sel,
  input wire packet_enable,
  input wire high_sensitivity,
  input wire prefilter_enable
);
  reg [3:0] rc_q;
  reg [31:0] hc_q;
  // Cycles since reset and cycles the time-out flag has stood
  always @(posedge clock) begin
    rc_q <= !rst_n ? 4'h0 : rc_q + {3'h0, rc_q != 4'hf};
    hc_q <= (rst_n && tx_timeout_flag) ? hc_q + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_carrier_field: assert property (carrier_sel == modem_control_word[2:0])
    else $error("carrier field wrong");
  a_baud_field: assert property (baud_sel == modem_control_word[4:3])
    else $error("baud field wrong");
  a_field_map: assert property ({prefilter_enable, high_sensitivity, packet_enable, packet_len_sel, packet_rate_sel,
    mclk_sel, async_mode, modem_control_word[13:12], zero_cross_sync, detect_time_sel, modem_control_word[8:7],
    watchdog_enable, deviation_full} == modem_control_word[23:5])
    else $error("field outputs wrong");
  a_band_qualify: assert property (rc_q > 4'h4 |-> band_busy_flag == $past(inband_signal && carrier_detect, 3))
    else $error("band flag wrong");
  a_cond_zero: assert property (rc_q > 4'h4 && modem_control_word[13:12] == 2'h1 && $stable(modem_control_word)
    && !$past(carrier_detect, 3) |-> !bit_clock_out && !rx_data_out) else $error("outputs not forced low");
  a_tx_entry: assert property ($rose(tx_enable) |-> $past(!direction_select && !config_select, 3))
    else $error("transmit without both selects low");
  a_timeout_exit: assert property (rc_q > 4'h4 && $rose(tx_timeout_flag) |-> $fell(tx_enable))
    else $error("time-out without leaving transmit");
  a_flag_hold: assert property ($fell(tx_timeout_flag) |-> hc_q >= HOLD_CYC)
    else $error("time-out flag too short");
  a_locked_no_tx: assert property (tx_timeout_flag |-> !tx_enable)
    else $error("transmit while timed out");
endmodule // modem_config_monitor
bind modem_config modem_config_monitor #(.HOLD_CYC(HOLD_CYC)) u_modem_config_monitor (.*);

/* tb/modem_config_tb.sv */
// Testbench for the modem control word block
`timescale 1ns/1ps
module modem_config_tb;
  localparam logic [23:0] DEF = {3'h0, 2'h2, 2'h1, 2'h2, 1'h1, 2'h2, 1'h0, 2'h1, 2'h1, 1'h1, 1'h0, 2'h2, 3'h7};
  logic clock, rst_n, carrier_detect, preamble_detect, pll_locked, inband_signal, rx_clock_raw, rx_data_raw;
  wire direction_select, config_select, word_valid, word_ready, bit_clock_out, rx_data_out;
  wire detect_notify_n, band_busy_flag, tx_timeout_flag, tx_enable;
  wire [23:0] word_in, modem_control_word;
  int bad_count = 0;
  int cmp_count = 0;
  host_model u_host_model (.*);
  modem_config #(.TX_TIMEOUT_FLAG_1S_CYC(100), .TX_TIMEOUT_FLAG_3S_CYC(300), .HOLD_CYC(20)) u_modem_config (.*, .carrier_sel(),
    .baud_sel(), .deviation_full(), .watchdog_enable(), .detect_time_sel(), .zero_cross_sync(), .async_mode(),
    .mclk_sel(), .packet_rate_sel(), .packet_len_sel(), .packet_enable(), .high_sensitivity(), .prefilter_enable());
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic t_defaults;
    int n = 0;
    chk("reset word", DEF, modem_control_word);
    chk("strap lock", 1, tx_timeout_flag);
    u_host_model.set_mode(1'b1, 1'b1);
    while (tx_timeout_flag === 1'b1 && n < 99) begin
      cyc(1);
      n++;
    end
    chk("unlock", 0, tx_timeout_flag);
    $display("test defaults done");
  endtask
  task automatic t_rx;
    logic [23:0] w;
    for (int m = 0; m < 4; m++) for (int p = 0; p < 2; p++) begin
      w = DEF;
      w[13:12] = m[1:0];
      u_host_model.send(w);
      @(posedge clock);
      #2 carrier_detect = p[0];
      pll_locked = p[0];
      cyc(6);
      chk("rx clock", p | !m[0], bit_clock_out);
      chk("rx data", p | !m[0], rx_data_out);
      chk("notify", !p[0], detect_notify_n);
      chk("band", p, band_busy_flag);
    end
    $display("test receive done");
  endtask
  task automatic t_tx_timeout_flag(input logic [1:0] code, input int lim, input bit brk);
    logic [23:0] w;
    int n = 0;
    w = DEF;
    w[8:7] = code;
    u_host_model.send(w);
    u_host_model.set_mode(1'b0, 1'b0);
    if (brk) begin
      cyc(lim - 20);
      u_host_model.set_mode(1'b1, 1'b0);
      cyc(8);
      u_host_model.set_mode(1'b0, 1'b0);
    end
    for (int i = 0; i < 10 && tx_enable !== 1'b1; i++) cyc(1);
    while (tx_enable === 1'b1 && n < lim + 9) begin
      cyc(1);
      n++;
    end
    chk("tx cycles", lim, n);
    chk("flag up", 1, tx_timeout_flag);
    cyc(8);
    chk("tx locked", 0, tx_enable);
    u_host_model.set_mode(1'b1, 1'b1);
    n = 0;
    while (tx_timeout_flag === 1'b1 && n < 99) begin
      cyc(1);
      n++;
    end
    chk("flag hold", 1, n + 8 >= 20 && n < 99);
    $display("test time-out %0d done", lim);
  endtask
  task automatic t_fifo;
    logic [23:0] w;
    int n = 0;
    w = DEF;
    w[8:7] = 2'h0;
    u_host_model.send(w);
    u_host_model.set_mode(1'b0, 1'b0);
    cyc(400);
    chk("tx kept", 1, tx_enable);
    while (word_ready === 1'b1 && n < 12) begin
      n++;
      u_host_model.send(w ^ 24'(n));
    end
    chk("fifo depth", 8, n);
    chk("word deferred", w, modem_control_word);
    u_host_model.set_mode(1'b1, 1'b0);
    cyc(30);
    chk("last word", w ^ 24'h8, modem_control_word);
    chk("drained", 1, word_ready);
    $display("test buffer done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    rst_n = 1'b0;
    carrier_detect = 1'b0;
    pll_locked = 1'b0;
    preamble_detect = 1'b1;
    inband_signal = 1'b1;
    rx_clock_raw = 1'b1;
    rx_data_raw = 1'b1;
    repeat (4) @(posedge clock);
    #2 rst_n = 1'b1;
    cyc(3);
    t_defaults();
    t_rx();
    t_tx_timeout_flag(2'h1, 100, 1'b0);
    t_tx_timeout_flag(2'h2, 300, 1'b0);
    t_tx_timeout_flag(2'h1, 100, 1'b1);
    t_fifo();
    report_and_stop();
  end
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
endmodule // modem_config_tb

/* verilog/modem_config.v */
// Modem control word, receive conditioning, band flag and transmit time-out
`timescale 1ns/1ps
`include "modem_cfg_consts.vh"
// Summary of operation
// - One 24-bit word holds all settings
// - Bits 0-2 pick carrier, default 132.5 kHz
// - Bits 3-4 pick baud, default 2400
// - Bit 5 picks deviation, default 0.5
// - Bit 6 enables 1.5 s watchdog, default on
// - Bits 7-8 pick time-out, default 1 s
// - Bits 9-10 pick detect filter, default 1 ms
// - Bit 11 enables zero-crossing sync, default off
// - Bits 12-13 pick detection method, default 10
// - Carrier conditioning zeroes clock, data without carrier
// - Preamble conditioning zeroes outputs unless locked, detected
// - Bit 14 picks async interface, default async
// - Bits 15-16 pick clock output, default 4 MHz
// - Bits 17-18 pick packet rate divider, default /64
// - Bits 19-20 pick packet length, default 14
// - Bit 21 enables packet mode, default off
// - Bit 22 high sensitivity, bit 23 pre-filter
// - Band flag qualified by internal carrier detect
// - Time-out forces receive after continuous transmit
// - Time-out flag held at least 125 ms
// - Timed out: only register access or receive
// - Reset with tx and config select arms protection
// - Transmit only when both selects are low
module modem_config #(
  parameter TX_TIMEOUT_FLAG_1S_CYC = `TX_TIMEOUT_FLAG_1S_MS * `CYC_PER_MS,
  parameter TX_TIMEOUT_FLAG_3S_CYC = `TX_TIMEOUT_FLAG_3S_MS * `CYC_PER_MS,
  parameter HOLD_CYC = `FLAG_HOLD_MS * `CYC_PER_MS,
  parameter FIFO_DEPTH = 8
) (
  input wire clock,
  input wire rst_n,
  input wire direction_select,
  input wire config_select,
  input wire word_valid,
  output wire word_ready,
  input wire [`CW_WIDTH-1:0] word_in,
  output wire [`CW_WIDTH-1:0] modem_control_word,
  input wire carrier_detect,
  input wire preamble_detect,
  input wire pll_locked,
  input wire inband_signal,
  input wire rx_clock_raw,
  input wire rx_data_raw,
  output reg bit_clock_out,
  output reg rx_data_out,
  output reg detect_notify_n,
  output reg band_busy_flag,
  output reg tx_timeout_flag,
  output reg tx_enable,
  output wire [2:0] carrier_sel,
  output wire [1:0] baud_sel,
  output wire deviation_full,
  output wire watchdog_enable,
  output wire [1:0] detect_time_sel,
  output wire zero_cross_sync,
  output wire async_mode,
  output wire [1:0] mclk_sel,
  output wire [1:0] packet_rate_sel,
  output wire [1:0] packet_len_sel,
  output wire packet_enable,
  output wire high_sensitivity,
  output wire prefilter_enable
);
  localparam ST_RX = 2'h0;
  localparam ST_TX = 2'h1;
  localparam ST_LOCK = 2'h2;
  localparam CW = 28;

  // Pin synchronisers: first stage feeds only the second
  // They run through reset so the strap pins are settled when reset ends
  reg [7:0] s1_q;
  reg [7:0] s2_q;
  wire dir_s = s2_q[0];
  wire cfg_s = s2_q[1];
  wire cd_s = s2_q[2];
  wire pd_s = s2_q[3];
  wire lock_s = s2_q[4];
  wire inb_s = s2_q[5];
  wire rxc_s = s2_q[6];
  wire rxd_s = s2_q[7];

  always @(posedge clock) begin
    s1_q <= {rx_data_raw, rx_clock_raw, inband_signal, pll_locked, preamble_detect,
             carrier_detect, config_select, direction_select};
    s2_q <= s1_q;
  end

  // Words arrive through the FIFO and are applied outside transmit
  reg [`CW_WIDTH-1:0] cw_q;
  wire fifo_valid;
  wire [`CW_WIDTH-1:0] fifo_data;
  reg [1:0] state_q;
  wire apply = fifo_valid && (state_q != ST_TX);

  word_fifo #(.WIDTH(`CW_WIDTH), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(word_valid),
    .in_ready(word_ready),
    .in_data(word_in),
    .out_valid(fifo_valid),
    .out_ready(apply),
    .out_data(fifo_data)
  );

  always @(posedge clock) begin
    if (!rst_n) begin
      cw_q <= `CW_RESET;
    end else if (apply) begin
      cw_q <= fifo_data;
    end
  end

  assign modem_control_word = cw_q;
  assign carrier_sel = cw_q[`CW_FREQ_MSB:`CW_FREQ_LSB];
  assign baud_sel = cw_q[`CW_BAUD_MSB:`CW_BAUD_LSB];
  assign deviation_full = cw_q[`CW_DEV_BIT];
  assign watchdog_enable = cw_q[`CW_WDOG_BIT];
  assign detect_time_sel = cw_q[`CW_DET_MSB:`CW_DET_LSB];
  assign zero_cross_sync = cw_q[`CW_ZC_BIT];
  assign async_mode = cw_q[`CW_ASYNC_BIT];
  assign mclk_sel = cw_q[`CW_MCLK_MSB:`CW_MCLK_LSB];
  assign packet_rate_sel = cw_q[`CW_PKBR_MSB:`CW_PKBR_LSB];
  assign packet_len_sel = cw_q[`CW_PKLEN_MSB:`CW_PKLEN_LSB];
  assign packet_enable = cw_q[`CW_PKEN_BIT];
  assign high_sensitivity = cw_q[`CW_SENS_BIT];
  assign prefilter_enable = cw_q[`CW_PREF_BIT];

  wire [1:0] tx_timeout_flag_sel = cw_q[`CW_TX_TIMEOUT_FLAG_MSB:`CW_TX_TIMEOUT_FLAG_LSB];
  wire [1:0] method = cw_q[`CW_METH_MSB:`CW_METH_LSB];
  wire use_preamble = method[1];
  wire conditioned = method[0];
  wire detected = use_preamble ? (pd_s && lock_s) : cd_s;

  // Receive outputs, with conditioning gate
  always @(posedge clock) begin
    if (!rst_n) begin
      bit_clock_out <= 1'b0;
      rx_data_out <= 1'b0;
      detect_notify_n <= 1'b1;
      band_busy_flag <= 1'b0;
    end else begin
      detect_notify_n <= !detected;
      band_busy_flag <= inb_s && cd_s;
      if (conditioned && !detected) begin
        bit_clock_out <= 1'b0;
        rx_data_out <= 1'b0;
      end else begin
        bit_clock_out <= rxc_s;
        rx_data_out <= rxd_s;
      end
    end
  end

  // Transmit time-out
  reg [CW-1:0] tx_cnt_q;
  reg [CW-1:0] hold_cnt_q;
  reg arm_q;
  wire [CW-1:0] limit = (tx_timeout_flag_sel == `TX_TIMEOUT_FLAG_3S) ? TX_TIMEOUT_FLAG_3S_CYC[CW-1:0] : TX_TIMEOUT_FLAG_1S_CYC[CW-1:0];
  wire tx_timeout_flag_on = (tx_timeout_flag_sel == `TX_TIMEOUT_FLAG_1S) || (tx_timeout_flag_sel == `TX_TIMEOUT_FLAG_3S);
  wire tx_req = !dir_s && !cfg_s;
  wire hold_done = (hold_cnt_q == HOLD_CYC[CW-1:0]);

  always @(posedge clock) begin
    if (!rst_n) begin
      state_q <= ST_RX;
      tx_cnt_q <= {CW{1'b0}};
      hold_cnt_q <= {CW{1'b0}};
      tx_timeout_flag <= 1'b0;
      tx_enable <= 1'b0;
      arm_q <= 1'b1;
    end else begin
      arm_q <= 1'b0;
      case (state_q)
        ST_RX: begin
          tx_cnt_q <= {CW{1'b0}};
          if (arm_q && !dir_s && cfg_s) begin
            state_q <= ST_LOCK;
            hold_cnt_q <= {CW{1'b0}};
            tx_timeout_flag <= 1'b1;
          end else if (tx_req && !arm_q) begin
            state_q <= ST_TX;
            tx_enable <= 1'b1;
          end
        end
        ST_TX: begin
          if (!tx_req) begin
            state_q <= ST_RX;
            tx_enable <= 1'b0;
            tx_cnt_q <= {CW{1'b0}};
          end else if (tx_timeout_flag_on && tx_cnt_q >= limit - 1'b1) begin
            state_q <= ST_LOCK;
            tx_enable <= 1'b0;
            tx_timeout_flag <= 1'b1;
            hold_cnt_q <= {CW{1'b0}};
          end else begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
          end
        end
        ST_LOCK: begin
          tx_enable <= 1'b0;
          if (!hold_done) begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
          end else if (dir_s) begin
            state_q <= ST_RX;
            tx_timeout_flag <= 1'b0;
            tx_cnt_q <= {CW{1'b0}};
          end
        end
        default: begin
          state_q <= ST_RX;
          tx_enable <= 1'b0;
        end
      endcase
    end
  end
endmodule // modem_config

/* verilog/word_fifo.v */
// Parameterised valid/ready FIFO
`timescale 1ns/1ps
module word_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clock,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH);
  assign out_valid = (cnt_q != 0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
    if (!rst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // word_fifo
